// ==== verilog/prbc_top.sv ====
// What this block does
// - All peripheral registers form one 256-byte block decoded as a single unit.
// - On the narrow bus a byte write still lands as a full 16-bit register write.
// - System group offsets FE, F6, F4, F2, F0, E6, E4, E0 are decoded.
// - DMA channel 1 decodes D0h-DAh, channel 0 decodes C0h-CAh.
// - Chip-select registers decode from A0h through A8h.
// - Timer registers decode from 50h, timer 2 at 60h, 62h, 66h.
// - Interrupt controller registers decode from 20h up to 44h.
// - Relocation register resets to 20FFh, block in memory space at 0FF00h.
// - Relocation bit 14 selects interrupt controller slave (1) or master (0).
// - Relocation bit 12 maps the block to I/O (1) or memory (0).
// - Relocation bits 11-0 give base address bits 19-8; low byte zero.
// - In I/O space, base address bits 19-16 are ignored when matching.
// - Strap register captures at reset release, read-only, held until next reset.
// - Strap source is bus 15-0, or upper outputs 15-8 plus bus 7-0 narrow.
// - Release level is read-only: code in bits 15-8, reserved bits 7-0.
// - Auxiliary register resets to zero; bits 15-7 reserved, fields in 6-0.
// - Auxiliary holds serial flow-pin selections and region bus width choices.
// - Auxiliary bits 2, 1, 0 force 8-bit low, mid and I/O accesses.
`include "prbc_map.svh"
`default_nettype none
module prbc_top #(
  parameter logic [7:0] RELEASE_CODE = 8'hA5 // Arbitrary release code value.
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic NARROW_BUS,
  input wire logic [15:0] MUX_BUS,
  input wire logic [7:0] UPPER_BUS_OUTPUTS,
  input wire logic ACCESS_VALID,
  input wire logic ACCESS_WRITE,
  input wire logic ACCESS_IO,
  input wire logic [19:0] ACCESS_ADDR,
  input wire logic [1:0] ACCESS_BYTE_EN,
  input wire logic [15:0] ACCESS_WDATA,
  output logic BLOCK_HIT,
  output prbc_pkg::prbc_group_t GROUP_SELECT,
  output logic [7:0] GROUP_OFFSET,
  output logic GROUP_WRITE,
  output logic GROUP_READ,
  output logic [15:0] GROUP_WDATA,
  output logic LOCAL_READ_VALID,
  output logic [15:0] READ_DATA,
  output logic IRQ_SLAVE_SELECT,
  output logic IO_SPACE_SELECT,
  output logic [11:0] BLOCK_BASE_FIELD,
  output logic PORT1_RECEIVE_GATE_SELECT,
  output logic PORT1_SEND_FLOW_SELECT,
  output logic PORT0_RECEIVE_GATE_SELECT,
  output logic PORT0_SEND_FLOW_SELECT,
  output logic LOW_REGION_BYTE_WIDTH,
  output logic MID_REGION_BYTE_WIDTH,
  output logic IO_REGION_BYTE_WIDTH
);
  logic rst_meta;
  logic rst_sync;
  logic [15:0] block_relocation;
  logic [15:0] next_block_relocation;
  logic [15:0] auxiliary_config;
  logic [15:0] next_auxiliary_config;
  logic [15:0] reset_strap_latch;
  logic [15:0] release_level;
  logic [15:0] next_read_data;
  logic next_local_read_valid;
  logic [15:0] next_group_wdata;
  logic [7:0] next_group_offset;
  prbc_pkg::prbc_group_t next_group_select;
  logic next_group_write;
  logic next_group_read;
  logic hit;
  logic even;
  logic [15:0] wr_word;
  prbc_pkg::prbc_group_t dec_group;

  // Reset is asserted at once but released through two flops to avoid a metastable release.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Block match: upper 12 address bits against the base; I/O drops bits 19-16.
  always_comb begin
    hit = 1'b0;
    if (ACCESS_VALID && (ACCESS_IO == block_relocation[`PRBC_RELOC_IO_BIT])) begin
      if (block_relocation[`PRBC_RELOC_IO_BIT]) begin
        hit = (ACCESS_ADDR[15:8] == block_relocation[7:0]);
      end else begin
        hit = (ACCESS_ADDR[19:8] == block_relocation[11:0]);
      end
    end
  end

  // The low address byte selects a register within the single 256-byte block.
  prbc_decode prbc_decode_inst (
    .offset(ACCESS_ADDR[7:0]),
    .group(dec_group),
    .even(even)
  );

  // Strap register: captured after reset release, never written afterward.
  prbc_strap prbc_strap_inst (
    .clk(SYS_CLK),
    .rst_n(rst_sync),
    .narrow_bus(NARROW_BUS),
    .mux_bus(MUX_BUS),
    .upper_bus_outputs(UPPER_BUS_OUTPUTS),
    .strap_value_field(reset_strap_latch)
  );

  // Release code sits in the upper byte; the reserved low byte reads zero.
  assign release_level = {RELEASE_CODE, 8'h00};

  // A byte write on the narrow bus still moves the full 16-bit word into the register,
  // so both halves are taken whole; only the wide bus honours a low-byte-only enable.
  always_comb begin
    wr_word = ACCESS_WDATA;
    if (NARROW_BUS) begin
      wr_word = {ACCESS_WDATA[15:8], ACCESS_WDATA[7:0]};
    end else if (ACCESS_BYTE_EN == 2'b01) begin
      wr_word = {block_relocation[15:8], ACCESS_WDATA[7:0]};
    end
  end

  // Register writes; read-only registers keep their contents and reserved bits load zero.
  always_comb begin
    next_block_relocation = block_relocation;
    next_auxiliary_config = auxiliary_config;
    if (hit && even && ACCESS_WRITE) begin
      case (ACCESS_ADDR[7:0])
        `PRBC_OFS_RELOC: begin
          next_block_relocation = wr_word & `PRBC_RELOC_WMASK;
        end
        `PRBC_OFS_AUX: begin
          next_auxiliary_config = wr_word & `PRBC_AUX_WMASK;
        end
        default: begin
          next_block_relocation = block_relocation;
        end
      endcase
    end
  end

  // Local reads answer one cycle later; other groups are answered by their peripheral.
  always_comb begin
    next_read_data = 16'h0000;
    next_local_read_valid = 1'b0;
    if (hit && even && !ACCESS_WRITE) begin
      case (ACCESS_ADDR[7:0])
        `PRBC_OFS_RELOC: begin
          next_read_data = block_relocation;
          next_local_read_valid = 1'b1;
        end
        `PRBC_OFS_STRAP: begin
          next_read_data = reset_strap_latch;
          next_local_read_valid = 1'b1;
        end
        `PRBC_OFS_RELEASE: begin
          next_read_data = release_level;
          next_local_read_valid = 1'b1;
        end
        `PRBC_OFS_AUX: begin
          next_read_data = auxiliary_config;
          next_local_read_valid = 1'b1;
        end
        default: begin
          next_local_read_valid = 1'b0;
        end
      endcase
    end
  end

  // Strobes to the peripheral groups carry the offset and widened data.
  always_comb begin
    next_group_select = hit ? dec_group : prbc_pkg::PRBC_GRP_NONE;
    next_group_offset = ACCESS_ADDR[7:0];
    next_group_wdata = wr_word;
    next_group_write = hit && ACCESS_WRITE && (dec_group != prbc_pkg::PRBC_GRP_NONE);
    next_group_read = hit && !ACCESS_WRITE && (dec_group != prbc_pkg::PRBC_GRP_NONE);
  end

  // Relocation and auxiliary registers load their fixed reset values.
  always_ff @(posedge SYS_CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      block_relocation <= `PRBC_RELOC_RESET;
      auxiliary_config <= `PRBC_AUX_RESET;
    end else begin
      block_relocation <= next_block_relocation;
      auxiliary_config <= next_auxiliary_config;
    end
  end

  // Registered outputs of the access path.
  always_ff @(posedge SYS_CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      READ_DATA <= 16'h0000;
      LOCAL_READ_VALID <= 1'b0;
      GROUP_SELECT <= prbc_pkg::PRBC_GRP_NONE;
      GROUP_OFFSET <= 8'h00;
      GROUP_WDATA <= 16'h0000;
      GROUP_WRITE <= 1'b0;
      GROUP_READ <= 1'b0;
    end else begin
      READ_DATA <= next_read_data;
      LOCAL_READ_VALID <= next_local_read_valid;
      GROUP_SELECT <= next_group_select;
      GROUP_OFFSET <= next_group_offset;
      GROUP_WDATA <= next_group_wdata;
      GROUP_WRITE <= next_group_write;
      GROUP_READ <= next_group_read;
    end
  end

  assign BLOCK_HIT = hit;

  // Relocation controls steer the interrupt controller and the block decode.
  assign IRQ_SLAVE_SELECT = block_relocation[`PRBC_RELOC_SLAVE_BIT];
  assign IO_SPACE_SELECT = block_relocation[`PRBC_RELOC_IO_BIT];
  assign BLOCK_BASE_FIELD = block_relocation[11:0];

  // Serial pin functions and region widths; the narrow bus forces all three regions to byte width.
  assign PORT1_RECEIVE_GATE_SELECT = auxiliary_config[6];
  assign PORT1_SEND_FLOW_SELECT = auxiliary_config[5];
  assign PORT0_RECEIVE_GATE_SELECT = auxiliary_config[4];
  assign PORT0_SEND_FLOW_SELECT = auxiliary_config[3];
  assign LOW_REGION_BYTE_WIDTH = NARROW_BUS | auxiliary_config[`PRBC_AUX_LOW_BIT];
  assign MID_REGION_BYTE_WIDTH = NARROW_BUS | auxiliary_config[`PRBC_AUX_MID_BIT];
  assign IO_REGION_BYTE_WIDTH = NARROW_BUS | auxiliary_config[`PRBC_AUX_IO_BIT];
endmodule
`default_nettype wire

// ==== verilog/prbc_map.svh ====
`ifndef PRBC_MAP_SVH
`define PRBC_MAP_SVH
// Register offsets inside the 256-byte peripheral register block.
`define PRBC_OFS_RELOC 8'hFE
`define PRBC_OFS_STRAP 8'hF6
`define PRBC_OFS_RELEASE 8'hF4
`define PRBC_OFS_AUX 8'hF2
`define PRBC_OFS_SYSCFG 8'hF0
`define PRBC_OFS_WDOG 8'hE6
`define PRBC_OFS_PRESCALE 8'hE4
`define PRBC_OFS_PARTITION 8'hE0
`define PRBC_OFS_DMA1_LO 8'hD0
`define PRBC_OFS_DMA1_HI 8'hDA
`define PRBC_OFS_DMA0_LO 8'hC0
`define PRBC_OFS_DMA0_HI 8'hCA
`define PRBC_OFS_CS_LO 8'hA0
`define PRBC_OFS_CS_HI 8'hA8
`define PRBC_OFS_SER0_LO 8'h80
`define PRBC_OFS_SER0_HI 8'h88
`define PRBC_OFS_PIO_LO 8'h70
`define PRBC_OFS_PIO_HI 8'h7A
`define PRBC_OFS_TMR_LO 8'h50
`define PRBC_OFS_TMR_HI 8'h5E
`define PRBC_OFS_TMR2_CNT 8'h60
`define PRBC_OFS_TMR2_CMPA 8'h62
`define PRBC_OFS_TMR2_CTL 8'h66
`define PRBC_OFS_IRQ_LO 8'h20
`define PRBC_OFS_IRQ_HI 8'h44
`define PRBC_OFS_SER1_LO 8'h10
`define PRBC_OFS_SER1_HI 8'h18
// Reset values and field layout.
`define PRBC_RELOC_RESET 16'h20FF
`define PRBC_AUX_RESET 16'h0000
`define PRBC_RELOC_WMASK 16'h5FFF
`define PRBC_AUX_WMASK 16'h007F
`define PRBC_RELOC_SLAVE_BIT 14
`define PRBC_RELOC_IO_BIT 12
`define PRBC_AUX_LOW_BIT 2
`define PRBC_AUX_MID_BIT 1
`define PRBC_AUX_IO_BIT 0
`endif

// ==== verilog/prbc_pkg.sv ====
`default_nettype none
package prbc_pkg;
  // Peripheral group an access is steered to.
  typedef enum logic [3:0] {
    PRBC_GRP_NONE, PRBC_GRP_SYSTEM, PRBC_GRP_DMA1, PRBC_GRP_DMA0, PRBC_GRP_CHIPSEL,
    PRBC_GRP_SERIAL0, PRBC_GRP_PIO, PRBC_GRP_TIMER, PRBC_GRP_IRQ, PRBC_GRP_SERIAL1
  } prbc_group_t;
  // Strap capture state.
  typedef enum logic [0:0] {PRBC_STRAP_WAIT, PRBC_STRAP_HELD} prbc_strap_t;
endpackage
`default_nettype wire

// ==== verilog/prbc_decode.sv ====
`include "prbc_map.svh"
`default_nettype none
module prbc_decode (
  input wire logic [7:0] offset,
  output prbc_pkg::prbc_group_t group,
  output logic even
);
  // Steer an aligned offset to its peripheral group; odd offsets decode nothing.
  always_comb begin
    even = ~offset[0];
    group = prbc_pkg::PRBC_GRP_NONE;
    if (offset == `PRBC_OFS_RELOC || offset == `PRBC_OFS_STRAP ||
        offset == `PRBC_OFS_RELEASE || offset == `PRBC_OFS_AUX ||
        offset == `PRBC_OFS_SYSCFG || offset == `PRBC_OFS_WDOG ||
        offset == `PRBC_OFS_PRESCALE || offset == `PRBC_OFS_PARTITION) begin
      group = prbc_pkg::PRBC_GRP_SYSTEM;
    end else if (offset >= `PRBC_OFS_DMA1_LO && offset <= `PRBC_OFS_DMA1_HI) begin
      group = prbc_pkg::PRBC_GRP_DMA1;
    end else if (offset >= `PRBC_OFS_DMA0_LO && offset <= `PRBC_OFS_DMA0_HI) begin
      group = prbc_pkg::PRBC_GRP_DMA0;
    end else if (offset >= `PRBC_OFS_CS_LO && offset <= `PRBC_OFS_CS_HI) begin
      group = prbc_pkg::PRBC_GRP_CHIPSEL;
    end else if (offset >= `PRBC_OFS_SER0_LO && offset <= `PRBC_OFS_SER0_HI) begin
      group = prbc_pkg::PRBC_GRP_SERIAL0;
    end else if (offset >= `PRBC_OFS_PIO_LO && offset <= `PRBC_OFS_PIO_HI) begin
      group = prbc_pkg::PRBC_GRP_PIO;
    end else if ((offset >= `PRBC_OFS_TMR_LO && offset <= `PRBC_OFS_TMR_HI) ||
                 offset == `PRBC_OFS_TMR2_CNT || offset == `PRBC_OFS_TMR2_CMPA ||
                 offset == `PRBC_OFS_TMR2_CTL) begin
      group = prbc_pkg::PRBC_GRP_TIMER;
    end else if (offset >= `PRBC_OFS_IRQ_LO && offset <= `PRBC_OFS_IRQ_HI) begin
      group = prbc_pkg::PRBC_GRP_IRQ;
    end else if (offset >= `PRBC_OFS_SER1_LO && offset <= `PRBC_OFS_SER1_HI) begin
      group = prbc_pkg::PRBC_GRP_SERIAL1;
    end
    if (offset[0]) begin
      group = prbc_pkg::PRBC_GRP_NONE;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/prbc_strap.sv ====
`include "prbc_map.svh"
`default_nettype none
module prbc_strap (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic narrow_bus,
  input wire logic [15:0] mux_bus,
  input wire logic [7:0] upper_bus_outputs,
  output logic [15:0] strap_value_field
);
  prbc_pkg::prbc_strap_t state;
  prbc_pkg::prbc_strap_t next_state;
  logic [15:0] next_strap_value_field;

  // Capture once at the first edge after reset release, then hold until the next reset.
  always_comb begin
    next_state = state;
    next_strap_value_field = strap_value_field;
    case (state)
      prbc_pkg::PRBC_STRAP_WAIT: begin
        next_state = prbc_pkg::PRBC_STRAP_HELD;
        next_strap_value_field = narrow_bus ? {upper_bus_outputs, mux_bus[7:0]}
                                            : mux_bus;
      end
      prbc_pkg::PRBC_STRAP_HELD: begin
        next_state = prbc_pkg::PRBC_STRAP_HELD;
      end
      default: begin
        next_state = prbc_pkg::PRBC_STRAP_WAIT;
      end
    endcase
  end

  // Asynchronous reset loads constants only; the pins are sampled after release.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= prbc_pkg::PRBC_STRAP_WAIT;
      strap_value_field <= 16'h0000;
    end else begin
      state <= next_state;
      strap_value_field <= next_strap_value_field;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/prbc_top_monitor.sv ====
`default_nettype none
module prbc_top_monitor (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic NARROW_BUS,
  input wire logic ACCESS_VALID,
  input wire logic ACCESS_WRITE,
  input wire logic ACCESS_IO,
  input wire logic [19:0] ACCESS_ADDR,
  input wire logic [15:0] ACCESS_WDATA,
  input wire logic BLOCK_HIT,
  input wire logic [7:0] GROUP_OFFSET,
  input wire logic GROUP_WRITE,
  input wire logic GROUP_READ,
  input wire logic [15:0] GROUP_WDATA,
  input wire logic LOCAL_READ_VALID,
  input wire logic IRQ_SLAVE_SELECT,
  input wire logic IO_SPACE_SELECT,
  input wire logic [11:0] BLOCK_BASE_FIELD,
  input wire logic PORT1_RECEIVE_GATE_SELECT,
  input wire logic PORT1_SEND_FLOW_SELECT,
  input wire logic PORT0_RECEIVE_GATE_SELECT,
  input wire logic PORT0_SEND_FLOW_SELECT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  logic take, lcl, exp_hit;
  // An I/O match looks only at address bits 15-8, so the top nibble can hold anything.
  assign exp_hit = ACCESS_IO ? (IO_SPACE_SELECT && ACCESS_ADDR[15:8] == BLOCK_BASE_FIELD[7:0])
    : (!IO_SPACE_SELECT && ACCESS_ADDR[19:8] == BLOCK_BASE_FIELD);
  assign take = ACCESS_VALID && BLOCK_HIT && !ACCESS_ADDR[0];
  assign lcl = ACCESS_ADDR[7:0] inside {8'hFE, 8'hF6, 8'hF4, 8'hF2};
  sequence s_wr_local;
    take && ACCESS_WRITE && lcl;
  endsequence
  sequence s_rd_local;
    take && !ACCESS_WRITE && lcl;
  endsequence
  a_hit_match: assert property (ACCESS_VALID |-> BLOCK_HIT == exp_hit)
    else $error("block hit disagrees with relocation");
  a_write_local: assert property (s_wr_local |=> GROUP_WRITE &&
    GROUP_OFFSET == $past(ACCESS_ADDR[7:0])) else $error("local write not passed on");
  a_write_cause: assert property (GROUP_WRITE |-> $past(take && ACCESS_WRITE))
    else $error("write pulse without a taken write");
  a_read_local: assert property (s_rd_local |=> LOCAL_READ_VALID && GROUP_READ)
    else $error("local read not answered");
  a_read_cause: assert property (LOCAL_READ_VALID |->
    $past(take && !ACCESS_WRITE && lcl)) else $error("local read valid without cause");
  a_narrow_data: assert property (GROUP_WRITE && NARROW_BUS |->
    GROUP_WDATA == $past(ACCESS_WDATA)) else $error("narrow write not widened whole");
  a_reloc_hold: assert property (!(take && ACCESS_WRITE && ACCESS_ADDR[7:0] == 8'hFE) |=>
    $stable({IRQ_SLAVE_SELECT, IO_SPACE_SELECT, BLOCK_BASE_FIELD}))
    else $error("relocation changed without a write");
  a_aux_hold: assert property (!(take && ACCESS_WRITE && ACCESS_ADDR[7:0] == 8'hF2) |=>
    $stable({PORT1_RECEIVE_GATE_SELECT, PORT1_SEND_FLOW_SELECT, PORT0_RECEIVE_GATE_SELECT,
    PORT0_SEND_FLOW_SELECT})) else $error("auxiliary changed without a write");
  a_odd_refused: assert property (ACCESS_VALID && ACCESS_ADDR[0] |=>
    !GROUP_WRITE && !GROUP_READ && !LOCAL_READ_VALID) else $error("odd access answered");
endmodule
bind prbc_top prbc_top_monitor prbc_top_monitor_inst (.SYS_CLK, .RSTN, .NARROW_BUS,
  .ACCESS_VALID, .ACCESS_WRITE, .ACCESS_IO, .ACCESS_ADDR, .ACCESS_WDATA, .BLOCK_HIT,
  .GROUP_OFFSET, .GROUP_WRITE, .GROUP_READ, .GROUP_WDATA, .LOCAL_READ_VALID,
  .IRQ_SLAVE_SELECT, .IO_SPACE_SELECT, .BLOCK_BASE_FIELD, .PORT1_RECEIVE_GATE_SELECT,
  .PORT1_SEND_FLOW_SELECT, .PORT0_RECEIVE_GATE_SELECT, .PORT0_SEND_FLOW_SELECT);
`default_nettype wire

// ==== testbench/prbc_cpu_model.sv ====
`default_nettype none
module prbc_cpu_model (
  input wire logic clk,
  output logic valid,
  output logic write,
  output logic io,
  output logic [19:0] addr,
  output logic [1:0] byte_en,
  output logic [15:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // The bus starts idle.
  initial begin
    valid = 1'b0;
    write = 1'b0;
    io = 1'b0;
    addr = 20'h00000;
    byte_en = 2'h0;
    wdata = 16'h0000;
  end
  // One access per cycle, entered at a falling edge; calls may follow back to back.
  task automatic acc(input logic w, input logic i, input logic [19:0] a,
    input logic [1:0] b, input logic [15:0] d);
    valid = 1'b1;
    write = w;
    io = i;
    addr = a;
    byte_en = b;
    wdata = d;
    @(negedge clk);
  endtask
  // Released lines show flipped leftovers so stale values cannot match by luck.
  task automatic idle;
    valid = 1'b0;
    addr = ~addr;
    wdata = ~wdata;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ==== testbench/prbc_top_tb.sv ====
`default_nettype none
module prbc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CODE = 8'h3C; // Arbitrary release code.
  typedef struct packed {logic [7:0] ofs; prbc_pkg::prbc_group_t grp;} prbc_row_t;
  logic sys_clk, rstn, narrow, valid, write, io, hit, gw, gr, lrv, slave, iosp;
  logic p1r, p1s, p0r, p0s, low, mid, iow;
  logic [1:0] be;
  logic [7:0] upper, goff;
  logic [11:0] base;
  logic [15:0] mux, wdata, gwd, rdata, reloc, auxv;
  logic [19:0] addr;
  prbc_pkg::prbc_group_t grp;
  int fails, compares, cycles;
  prbc_row_t rows [16] = '{
    '{8'hFE, prbc_pkg::PRBC_GRP_SYSTEM}, '{8'hE0, prbc_pkg::PRBC_GRP_SYSTEM},
    '{8'hD0, prbc_pkg::PRBC_GRP_DMA1}, '{8'hC0, prbc_pkg::PRBC_GRP_DMA0},
    '{8'hCA, prbc_pkg::PRBC_GRP_DMA0}, '{8'hA0, prbc_pkg::PRBC_GRP_CHIPSEL},
    '{8'hA8, prbc_pkg::PRBC_GRP_CHIPSEL}, '{8'h70, prbc_pkg::PRBC_GRP_PIO},
    '{8'h7A, prbc_pkg::PRBC_GRP_PIO}, '{8'h50, prbc_pkg::PRBC_GRP_TIMER},
    '{8'h66, prbc_pkg::PRBC_GRP_TIMER}, '{8'h20, prbc_pkg::PRBC_GRP_IRQ},
    '{8'h44, prbc_pkg::PRBC_GRP_IRQ}, '{8'h80, prbc_pkg::PRBC_GRP_SERIAL0},
    '{8'h10, prbc_pkg::PRBC_GRP_SERIAL1}, '{8'h00, prbc_pkg::PRBC_GRP_NONE}};
  // Packed views of the relocation and auxiliary outputs.
  assign reloc = {1'b0, slave, 1'b0, iosp, base};
  assign auxv = {9'h000, p1r, p1s, p0r, p0s, low, mid, iow};
  prbc_top #(.RELEASE_CODE(CODE)) prbc_top_inst (.SYS_CLK(sys_clk), .RSTN(rstn),
    .NARROW_BUS(narrow), .MUX_BUS(mux), .UPPER_BUS_OUTPUTS(upper), .ACCESS_VALID(valid),
    .ACCESS_WRITE(write), .ACCESS_IO(io), .ACCESS_ADDR(addr), .ACCESS_BYTE_EN(be),
    .ACCESS_WDATA(wdata), .BLOCK_HIT(hit), .GROUP_SELECT(grp), .GROUP_OFFSET(goff),
    .GROUP_WRITE(gw), .GROUP_READ(gr), .GROUP_WDATA(gwd), .LOCAL_READ_VALID(lrv),
    .READ_DATA(rdata), .IRQ_SLAVE_SELECT(slave), .IO_SPACE_SELECT(iosp),
    .BLOCK_BASE_FIELD(base), .PORT1_RECEIVE_GATE_SELECT(p1r), .PORT1_SEND_FLOW_SELECT(p1s),
    .PORT0_RECEIVE_GATE_SELECT(p0r), .PORT0_SEND_FLOW_SELECT(p0s),
    .LOW_REGION_BYTE_WIDTH(low), .MID_REGION_BYTE_WIDTH(mid), .IO_REGION_BYTE_WIDTH(iow));
  prbc_cpu_model prbc_cpu_model_inst (.clk(sys_clk), .valid(valid), .write(write), .io(io),
    .addr(addr), .byte_en(be), .wdata(wdata));
  // Free-running system clock.
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // A hung run counts as a mismatch.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      print_verdict;
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ac(input logic [1:0] wi, input logic [19:0] a, input logic [1:0] b,
    input logic [15:0] d);
    prbc_cpu_model_inst.acc(wi[1], wi[0], a, b, d);
  endtask
  // Strap pins move right after capture, so a held value proves the latch closed.
  task automatic do_reset(input logic n, input logic [15:0] m, input logic [7:0] u);
    rstn = 1'b0;
    narrow = n;
    mux = m;
    upper = u;
    repeat (10) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
    mux = ~m;
    upper = ~u;
  endtask
  task automatic print_verdict;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    fails = 0;
    compares = 0;
    cycles = 0;
    rstn = 1'b0;
    narrow = 1'b0;
    mux = 16'h0000;
    upper = 8'h00;
    do_reset(1'b0, 16'hC3A5, 8'h5A);
    chk("reloc", 16'h00FF, reloc);
    chk("aux", 16'h0000, auxv);
    for (int i = 0; i < 16; i++) begin
      ac(2'h0, {12'h0FF, rows[i].ofs}, 2'h3, 16'h0000);
      chk("group", {12'h000, rows[i].grp}, {12'h000, grp});
      if (rows[i].grp != prbc_pkg::PRBC_GRP_NONE) begin
        chk("offset", {8'h00, rows[i].ofs}, {8'h00, goff});
        chk("rpulse", 16'h0001, {15'h0000, gr});
      end
    end
    ac(2'h0, 20'h0FFFE, 2'h3, 16'h0000);
    chk("relrd", 16'h20FF, rdata);
    ac(2'h2, 20'h0FFF6, 2'h3, 16'h0000);
    ac(2'h2, 20'h0FFF4, 2'h3, 16'h0000);
    ac(2'h0, 20'h0FFF6, 2'h3, 16'h0000);
    chk("strap", 16'hC3A5, rdata);
    ac(2'h0, 20'h0FFF4, 2'h3, 16'h0000);
    chk("release", {8'h00, CODE}, {8'h00, rdata[15:8]});
    ac(2'h2, 20'h0FFF2, 2'h3, 16'hFFFF);
    chk("auxall", 16'h007F, auxv);
    ac(2'h2, 20'h0FFF2, 2'h3, 16'h0005);
    ac(2'h2, 20'h0FFF3, 2'h3, 16'h0000);
    chk("oddwr", 16'h0000, {15'h0000, gw});
    ac(2'h0, 20'h0FFF2, 2'h3, 16'h0000);
    chk("auxrd", 16'h0005, rdata);
    chk("widths", 16'h0005, auxv);
    ac(2'h2, 20'h0FFFE, 2'h1, 16'h5034);
    chk("bytewr", 16'h0034, reloc);
    ac(2'h0, 20'h0FFF2, 2'h3, 16'h0000);
    chk("oldmiss", 16'h0000, {15'h0000, lrv});
    ac(2'h2, 20'h034FE, 2'h3, 16'h5123);
    chk("relio", 16'h5123, reloc);
    ac(2'h1, 20'hA23F2, 2'h3, 16'h0000);
    chk("iohit", 16'h0005, rdata);
    chk("iohitf", 16'h0001, {15'h0000, hit});
    ac(2'h0, 20'h123F2, 2'h3, 16'h0000);
    chk("memmiss", 16'h0000, {15'h0000, lrv});
    ac(2'h1, 20'h023FE, 2'h3, 16'h0000);
    chk("relrd2", 16'h5123, rdata);
    prbc_cpu_model_inst.idle;
    do_reset(1'b1, 16'h1234, 8'hAB);
    chk("reloc2", 16'h00FF, reloc);
    chk("narrow", 16'h0007, auxv);
    ac(2'h0, 20'h0FFF6, 2'h3, 16'h0000);
    chk("strap8", 16'hAB34, rdata);
    ac(2'h2, 20'h0FFFE, 2'h1, 16'h40FF);
    chk("wide16", 16'h40FF, gwd);
    chk("slave", 16'h40FF, reloc);
    prbc_cpu_model_inst.idle;
    print_verdict;
  end
endmodule
`default_nettype wire
